/* shared/gpte_regs.vh */
`ifndef GPTE_REGS_VH
`define GPTE_REGS_VH
// ***********************************************************
// Parameter block layout (word index from request base)
// ***********************************************************
`define GPTE_PW_OPT 3'h0
`define GPTE_PW_NEXT 3'h1
`define GPTE_PW_BASE 3'h2
`define GPTE_PW_CNT 3'h3
`define GPTE_PW_NDELTA 3'h4
`define GPTE_PW_TABLE 3'h5
`define GPTE_PW_FILL_LO 3'h6
`define GPTE_PW_FILL_HI 3'h7
`define GPTE_PW_LAST 3'h7
// ***********************************************************
// Option word fields
// ***********************************************************
`define GPTE_SRC_MODE_HI 14
`define GPTE_SRC_MODE_LO 12
`define GPTE_DST_MODE_HI 6
`define GPTE_DST_MODE_LO 4
`define GPTE_OPT_OFFSET_BIT 8
`define GPTE_OPT_LINK_BIT 31
// ***********************************************************
// Operating modes
// ***********************************************************
`define GPTE_MODE_DIM 3'h0
`define GPTE_MODE_FIXED 3'h2
`define GPTE_MODE_VAR 3'h3
`define GPTE_MODE_FILL 3'h4
// ***********************************************************
// Count word fields and address steps
// ***********************************************************
`define GPTE_ACNT_HI 15
`define GPTE_ACNT_LO 0
`define GPTE_BCNT_HI 31
`define GPTE_BCNT_LO 16
`define GPTE_WORD_STEP 32'h0000_0004
`define GPTE_PIX_STEP 32'h0000_0001
`endif

/* test/gpte_chk.sv */
`timescale 1ns/1ps
// ****
// Port checks
// ****
module gpte_chk (
  // Clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // Watched ports
  input wire req_valid_i,
  input wire req_queued_o,
  input wire done_irq_o,
  input wire [31:0] list_ptr_o,
  input wire sram_rd_o,
  input wire sram_rvalid_i,
  input wire mem_rd_o,
  input wire mem_wr_o,
  input wire [31:0] mem_addr_o,
  input wire [63:0] mem_wdata_o,
  input wire mem_ack_i
);
  reg rd_open_reg;
  always @(posedge clk_sys_i) begin
    if (!resetn_i) rd_open_reg <= 1'b0;
    else if (sram_rd_o) rd_open_reg <= 1'b1;
    else if (sram_rvalid_i) rd_open_reg <= 1'b0;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_req_taken: assert property (req_valid_i && !req_queued_o |=> req_queued_o)
    else $error("request not taken");
  a_rd_single: assert property (sram_rd_o |-> !rd_open_reg) else $error("second read");
  a_rd_pulse: assert property (sram_rd_o |=> !sram_rd_o) else $error("read pulse long");
  a_irq_pulse: assert property (done_irq_o |=> !done_irq_o) else $error("irq long");
  a_ptr_load: assert property ($changed(list_ptr_o) |-> done_irq_o ||
    $past(req_valid_i && !req_queued_o)) else $error("pointer moved");
  a_wr_hold: assert property (mem_wr_o && !mem_ack_i |=> mem_wr_o && $stable(mem_addr_o)
    && $stable(mem_wdata_o)) else $error("write dropped");
  a_mrd_hold: assert property (mem_rd_o && !mem_ack_i |=> mem_rd_o) else $error("read dropped");
  a_one_access: assert property (!(mem_rd_o && mem_wr_o)) else $error("read and write");
  a_idle_quiet: assert property (!req_queued_o |-> !mem_wr_o && !mem_rd_o && !sram_rd_o)
    else $error("access while idle");
  a_reset_clear: assert property (disable iff (1'b0) !resetn_i |=> !req_queued_o
    && !done_irq_o && !mem_wr_o) else $error("reset not clear");
endmodule // gpte_chk
bind gpte_engine gpte_chk u_chk (.clk_sys_i, .resetn_i, .req_valid_i, .req_queued_o,
  .done_irq_o, .list_ptr_o, .sram_rd_o, .sram_rvalid_i, .mem_rd_o, .mem_wr_o,
  .mem_addr_o, .mem_wdata_o, .mem_ack_i);

/* test/gpte_far_model.sv */
`timescale 1ns/1ps
// ****
// Shared RAM and off-chip memory
// ****
module gpte_far_model (
  // Clock and pace
  input wire clk_sys_i,
  input wire slow_i,
  // Shared RAM side
  input wire sram_rd_i,
  input wire [31:0] sram_addr_i,
  output reg [31:0] sram_rdata_o = 32'h0,
  output reg sram_rvalid_o = 1'b0,
  // Memory side
  input wire mem_rd_i,
  input wire mem_wr_i,
  input wire [31:0] mem_addr_i,
  output reg [63:0] mem_rdata_o = 64'h0,
  output reg mem_ack_o = 1'b0
);
  reg [31:0] ram [0:63];
  reg [31:0] addr_reg = 32'h0;
  reg [1:0] wait_reg = 2'h0;
  reg busy_reg = 1'b0;
  reg mwait_reg = 1'b0;
  // Idle data lines toggle so stale values never look valid
  always @(posedge clk_sys_i) begin
    sram_rvalid_o <= 1'b0;
    sram_rdata_o <= ~sram_rdata_o;
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (sram_rd_i) begin
      busy_reg <= 1'b1;
      addr_reg <= sram_addr_i;
      wait_reg <= slow_i ? 2'h2 : 2'h0;
    end else if (busy_reg && wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
    end else if (busy_reg) begin
      busy_reg <= 1'b0;
      sram_rvalid_o <= 1'b1;
      sram_rdata_o <= ram[addr_reg[7:2]];
    end
    if ((mem_rd_i || mem_wr_i) && !mem_ack_o) begin
      mwait_reg <= slow_i && !mwait_reg;
      mem_ack_o <= !slow_i || mwait_reg;
      // Read data tells which address it came from
      if (mem_rd_i && (!slow_i || mwait_reg)) mem_rdata_o <= {mem_addr_i, ~mem_addr_i};
    end
  end
endmodule // gpte_far_model

/* test/tb.sv */
`timescale 1ns/1ps
// ****
// Guided transfer bench
// ****
module tb;
  reg clk_sys_i = 1'b0;
  reg resetn_i = 1'b0;
  reg req_valid_i = 1'b0;
  reg [31:0] req_addr_i = 32'h0;
  reg slow = 1'b0;
  wire req_queued_o, done_irq_o, sram_rd_o, sram_rvalid_i, mem_rd_o, mem_wr_o, mem_ack_i;
  wire [31:0] list_ptr_o, sram_addr_o, sram_rdata_i, mem_addr_o;
  wire [63:0] mem_wdata_o, mem_rdata_i;
  integer failures = 0;
  integer check_count = 0;
  integer nw = 0;
  integer nr = 0;
  integer ni = 0;
  reg [31:0] wa [0:7];
  reg [63:0] wd [0:7];
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  gpte_engine u_dut (.clk_sys_i, .resetn_i, .req_valid_i, .req_addr_i, .req_queued_o,
    .done_irq_o, .list_ptr_o, .sram_rd_o, .sram_addr_o, .sram_rdata_i, .sram_rvalid_i,
    .mem_rd_o, .mem_wr_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i);
  gpte_far_model u_far (.clk_sys_i, .slow_i(slow), .sram_rd_i(sram_rd_o),
    .sram_addr_i(sram_addr_o), .sram_rdata_o(sram_rdata_i), .sram_rvalid_o(sram_rvalid_i),
    .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o),
    .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i));
  // Counters restart at the edge that takes a request
  always @(posedge clk_sys_i) begin
    if (req_valid_i && !req_queued_o) begin
      nw <= 0;
      nr <= 0;
      ni <= 0;
    end else begin
      if (mem_wr_o && mem_ack_i) begin
        wa[nw[2:0]] <= mem_addr_o;
        wd[nw[2:0]] <= mem_wdata_o;
        nw <= nw + 1;
      end
      if (mem_rd_o && mem_ack_i) nr <= nr + 1;
      if (done_irq_o) ni <= ni + 1;
    end
  end
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("ERROR %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("failures %0d checks %0d", failures, check_count);
      if (failures == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task blk(input integer w, input [31:0] opt, nxt, base, cnt, nd, tab);
    begin
      u_far.ram[w] = opt;
      u_far.ram[w+1] = nxt;
      u_far.ram[w+2] = base;
      u_far.ram[w+3] = cnt;
      u_far.ram[w+4] = nd;
      u_far.ram[w+5] = tab;
      u_far.ram[w+6] = 32'h5a5a_5a5a;
      u_far.ram[w+7] = 32'h5a5a_5a5a;
    end
  endtask
  task go(input [31:0] a, input integer n, input integer irq, input integer rd);
    integer t;
    begin
      req_addr_i <= a;
      req_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      req_valid_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      for (t = 0; t < 3000 && req_queued_o === 1'b1; t = t + 1) begin
        @(posedge clk_sys_i);
        #1;
      end
      chk(req_queued_o, 1'b0);
      chk(done_irq_o, 1'b1);
      @(posedge clk_sys_i);
      #1;
      chk(done_irq_o, 1'b0);
      chk(nw, n);
      chk(ni, irq);
      chk(nr, rd);
      @(posedge clk_sys_i);
    end
  endtask
  task t_fill(input s);
    begin
      slow <= s;
      blk(0, 32'h8000_4020, 32'h80, 32'h1000_0000, 32'h1, 32'h3, 32'h40);
      u_far.ram[16] = 32'h3;
      u_far.ram[17] = 32'h5;
      u_far.ram[18] = 32'h10;
      go(32'h0, 3, 1, 0);
      chk(wa[0], 32'h1000_0003);
      chk(wa[1], 32'h1000_0008);
      chk(wa[2], 32'h1000_0018);
      chk(wd[2], {2{32'h5a5a_5a5a}});
      chk(list_ptr_o, 32'h80);
    end
  endtask
  task t_link;
    begin
      blk(0, 32'h0000_4020, 32'h80, 32'h1000_0000, 32'h1, 32'h1, 32'h40);
      blk(32, 32'h8000_4020, 32'h100, 32'h2000_0000, 32'h1, 32'h1, 32'hc0);
      u_far.ram[48] = 32'h7;
      go(32'h0, 2, 2, 0);
      chk(wa[0], 32'h1000_0003);
      chk(wa[1], 32'h2000_0007);
      chk(list_ptr_o, 32'h100);
    end
  endtask
  task t_var;
    begin
      blk(0, 32'h8000_4030, 32'h80, 32'h3000_0000, 32'h5, 32'h2, 32'h40);
      u_far.ram[16] = 32'h4;
      u_far.ram[17] = 32'h1;
      u_far.ram[18] = 32'h8;
      u_far.ram[19] = 32'h1;
      go(32'h0, 2, 1, 0);
      chk(wa[0], 32'h3000_0004);
      chk(wa[1], 32'h3000_000c);
    end
  endtask
  task t_copy;
    begin
      blk(0, 32'h8000_0020, 32'h80, 32'h4000_0000, 32'h2, 32'h1, 32'h40);
      u_far.ram[16] = 32'h10;
      go(32'h0, 2, 1, 2);
      chk(wa[0], 32'h4000_0010);
      chk(wd[0], {32'h4000_0010, 32'hbfff_ffef});
      chk(wa[1], 32'h4000_0011);
      chk(wd[1], {32'h4000_0011, 32'hbfff_ffee});
    end
  endtask
  task t_rst;
    begin
      req_addr_i <= 32'h0;
      req_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      req_valid_i <= 1'b0;
      repeat (20) @(posedge clk_sys_i);
      #1;
      chk(req_queued_o, 1'b1);
      @(posedge clk_sys_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk(req_queued_o, 1'b0);
      chk(done_irq_o, 1'b0);
      chk(list_ptr_o, 32'h0);
      @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      @(posedge clk_sys_i);
      go(32'h0, 2, 1, 0);
      chk(wa[1], 32'h3000_000c);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    t_fill(1'b0);
    t_fill(1'b1);
    t_link;
    t_var;
    t_rst;
    t_copy;
    summarize;
  end
  initial begin
    #200000;
    failures = failures + 1;
    summarize;
  end
endmodule // tb

/* verilog/gpte_engine.v */
`timescale 1ns/1ps
`include "gpte_regs.vh"
module gpte_engine (
  // Clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // Request port
  input wire req_valid_i,
  input wire [31:0] req_addr_i,
  output reg req_queued_o,
  output reg done_irq_o,
  output reg [31:0] list_ptr_o,
  // Shared RAM read port
  output reg sram_rd_o,
  output reg [31:0] sram_addr_o,
  input wire [31:0] sram_rdata_i,
  input wire sram_rvalid_i,
  // Off-chip memory port
  output reg mem_rd_o,
  output reg mem_wr_o,
  output reg [31:0] mem_addr_o,
  output reg [63:0] mem_wdata_o,
  input wire [63:0] mem_rdata_i,
  input wire mem_ack_i
);
  // ***********************************************************
  // States
  // ***********************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_PARM = 3'h1;
  localparam [2:0] ST_ENTRY = 3'h2;
  localparam [2:0] ST_SIZE = 3'h3;
  localparam [2:0] ST_PIX = 3'h4;
  localparam [2:0] ST_DONE = 3'h5;

  function [2:0] field_mode;
    input [31:0] opt;
    input dst;
    begin
      if (dst) begin
        field_mode = opt[`GPTE_DST_MODE_HI:`GPTE_DST_MODE_LO];
      end else begin
        field_mode = opt[`GPTE_SRC_MODE_HI:`GPTE_SRC_MODE_LO];
      end
    end
  endfunction

  reg [2:0] state_reg;
  reg [2:0] pidx_reg;
  reg [31:0] prm_reg [0:7];
  reg [31:0] entry_cnt_reg;
  reg [31:0] tbl_addr_reg;
  reg [31:0] patch_base_reg;
  reg [31:0] prev_base_reg;
  reg [15:0] acnt_reg;
  reg [15:0] bcnt_reg;
  reg [15:0] a_reg;
  reg [15:0] b_reg;
  reg [31:0] row_addr_reg;
  reg [31:0] pix_addr_reg;
  reg busy_wait_reg;
  reg [63:0] rd_data_reg;
  reg wr_phase_reg;

  wire [31:0] opt_w = prm_reg[`GPTE_PW_OPT];
  wire [2:0] src_mode_w = field_mode(opt_w, 1'b0);
  wire [2:0] dst_mode_w = field_mode(opt_w, 1'b1);
  wire fill_w = (src_mode_w == `GPTE_MODE_FILL);
  wire var_w = (dst_mode_w == `GPTE_MODE_VAR) || (src_mode_w == `GPTE_MODE_VAR);
  wire offset_w = opt_w[`GPTE_OPT_OFFSET_BIT];
  wire linked_w = ~opt_w[`GPTE_OPT_LINK_BIT];
  wire last_a_w = (a_reg + 16'h0001 >= acnt_reg);
  wire last_b_w = (b_reg >= bcnt_reg);
  wire [31:0] entry_addr_w = offset_w ? (prm_reg[`GPTE_PW_BASE] + sram_rdata_i)
                                      : (prev_base_reg + sram_rdata_i);

  // ***********************************************************
  // Sequencer
  // ***********************************************************
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      pidx_reg <= 3'h0;
      entry_cnt_reg <= 32'h0;
      tbl_addr_reg <= 32'h0;
      patch_base_reg <= 32'h0;
      prev_base_reg <= 32'h0;
      acnt_reg <= 16'h0;
      bcnt_reg <= 16'h0;
      a_reg <= 16'h0;
      b_reg <= 16'h0;
      row_addr_reg <= 32'h0;
      pix_addr_reg <= 32'h0;
      busy_wait_reg <= 1'b0;
      rd_data_reg <= 64'h0;
      wr_phase_reg <= 1'b0;
      req_queued_o <= 1'b0;
      done_irq_o <= 1'b0;
      list_ptr_o <= 32'h0;
      sram_rd_o <= 1'b0;
      sram_addr_o <= 32'h0;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= 32'h0;
      mem_wdata_o <= 64'h0;
    end else begin
      done_irq_o <= 1'b0;
      sram_rd_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (req_valid_i) begin
            list_ptr_o <= req_addr_i;
            req_queued_o <= 1'b1;
            pidx_reg <= 3'h0;
            busy_wait_reg <= 1'b0;
            state_reg <= ST_PARM;
          end
        end
        ST_PARM: begin
          if (!busy_wait_reg) begin
            sram_rd_o <= 1'b1;
            sram_addr_o <= list_ptr_o + {27'h0, pidx_reg, 2'h0};
            busy_wait_reg <= 1'b1;
          end else if (sram_rvalid_i) begin
            prm_reg[pidx_reg] <= sram_rdata_i;
            busy_wait_reg <= 1'b0;
            pidx_reg <= pidx_reg + 3'h1;
            if (pidx_reg == `GPTE_PW_LAST) begin
              state_reg <= ST_ENTRY;
            end
          end
          entry_cnt_reg <= 32'h0;
          tbl_addr_reg <= prm_reg[`GPTE_PW_TABLE];
          prev_base_reg <= prm_reg[`GPTE_PW_BASE];
        end
        ST_ENTRY: begin
          if (entry_cnt_reg >= prm_reg[`GPTE_PW_NDELTA]) begin
            state_reg <= ST_DONE;
          end else if (!busy_wait_reg) begin
            sram_rd_o <= 1'b1;
            sram_addr_o <= tbl_addr_reg;
            busy_wait_reg <= 1'b1;
          end else if (sram_rvalid_i) begin
            busy_wait_reg <= 1'b0;
            tbl_addr_reg <= tbl_addr_reg + `GPTE_WORD_STEP;
            patch_base_reg <= entry_addr_w;
            prev_base_reg <= entry_addr_w;
            acnt_reg <= prm_reg[`GPTE_PW_CNT][`GPTE_ACNT_HI:`GPTE_ACNT_LO];
            bcnt_reg <= prm_reg[`GPTE_PW_CNT][`GPTE_BCNT_HI:`GPTE_BCNT_LO];
            if (var_w) begin
              tbl_addr_reg <= tbl_addr_reg + `GPTE_WORD_STEP + `GPTE_WORD_STEP;
              state_reg <= ST_SIZE;
            end else begin
              row_addr_reg <= entry_addr_w;
              pix_addr_reg <= entry_addr_w;
              a_reg <= 16'h0;
              b_reg <= 16'h0;
              wr_phase_reg <= 1'b0;
              state_reg <= ST_PIX;
            end
          end
        end
        ST_SIZE: begin
          if (!busy_wait_reg) begin
            sram_rd_o <= 1'b1;
            sram_addr_o <= tbl_addr_reg - `GPTE_WORD_STEP;
            busy_wait_reg <= 1'b1;
          end else if (sram_rvalid_i) begin
            busy_wait_reg <= 1'b0;
            acnt_reg <= sram_rdata_i[`GPTE_ACNT_HI:`GPTE_ACNT_LO];
            bcnt_reg <= sram_rdata_i[`GPTE_BCNT_HI:`GPTE_BCNT_LO];
            row_addr_reg <= patch_base_reg;
            pix_addr_reg <= patch_base_reg;
            a_reg <= 16'h0;
            b_reg <= 16'h0;
            wr_phase_reg <= 1'b0;
            state_reg <= ST_PIX;
          end
        end
        ST_PIX: begin
          if (!mem_rd_o && !mem_wr_o) begin
            mem_addr_o <= pix_addr_reg;
            if (fill_w || wr_phase_reg) begin
              mem_wr_o <= 1'b1;
              mem_wdata_o <= fill_w ? {prm_reg[`GPTE_PW_FILL_HI],
                                       prm_reg[`GPTE_PW_FILL_LO]}
                                    : rd_data_reg;
            end else begin
              mem_rd_o <= 1'b1;
            end
          end else if (mem_ack_i) begin
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            if (mem_rd_o) begin
              rd_data_reg <= mem_rdata_i;
              wr_phase_reg <= 1'b1;
            end else begin
              wr_phase_reg <= 1'b0;
              if (!last_a_w) begin
                a_reg <= a_reg + 16'h0001;
                pix_addr_reg <= pix_addr_reg + `GPTE_PIX_STEP;
              end else if (!last_b_w) begin
                a_reg <= 16'h0;
                b_reg <= b_reg + 16'h0001;
                row_addr_reg <= row_addr_reg + prm_reg[`GPTE_PW_TABLE - 3'h1];
                pix_addr_reg <= row_addr_reg + prm_reg[`GPTE_PW_TABLE - 3'h1];
              end else begin
                entry_cnt_reg <= entry_cnt_reg + 32'h1;
                state_reg <= ST_ENTRY;
              end
            end
          end
        end
        ST_DONE: begin
          list_ptr_o <= prm_reg[`GPTE_PW_NEXT];
          done_irq_o <= 1'b1;
          pidx_reg <= 3'h0;
          if (linked_w) begin
            state_reg <= ST_PARM;
          end else begin
            req_queued_o <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // gpte_engine
